//--- tcc_timer_channels.sv
// Function
// - active pin edge copies counter into value
// - software picks capture edge polarity per channel
// - capture sets flag, enabled flag requests interrupt
// - compare match sets, clears or inverts pin
// - compare match sets flag, optional interrupt
// - unbuffered channel compares its own value directly
// - new value acts at once, misses allowed
// - pair01 link buffers 0/1 onto pin 0
// - written inactive register takes over at overflow
// - linked odd control ignored, odd pin released
// - pair23 link buffers 2/3 onto pin 2
// - toggle-on-overflow inverts pin at overflow
// - modulo 255 gives 256-clock pwm period
// - value 128 of 256 gives half duty
// - overflow flag set on rollover after modulo
// - without overflow toggle, clear-on-match output stays at 0%
// - max duty without overflow toggle forces 100%
// - link bit outranks lower mode bit
`timescale 1ns/1ns
`default_nettype none
module tcc_timer_channels
(
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_enable,
    input wire logic [15:0] i_modulo,
    input wire logic i_overflow_clear,
    input wire logic i_pair01_link_bit,
    input wire logic i_pair23_link_bit,
    input wire logic [3:0] i_mode_low_bit,
    input wire logic [3:0] i_sel_high,
    input wire logic [3:0] i_sel_low,
    input wire logic [3:0] i_toggle_on_overflow,
    input wire logic [3:0] i_max_duty_bit,
    input wire logic [3:0] i_irq_enable,
    input wire logic [3:0] i_flag_clear,
    input wire logic [3:0] i_value_write,
    input wire logic [15:0] i_value_data,
    input wire logic [3:0] i_chan_pin,
    output logic [15:0] o_counter,
    output logic o_overflow_flag,
    output logic [3:0] o_chan_flag,
    output logic [3:0] o_chan_irq,
    output logic [3:0] o_chan_pin,
    output logic [3:0] o_chan_pin_oe,
    output logic [15:0] o_chan0_value,
    output logic [15:0] o_chan1_value,
    output logic [15:0] o_chan2_value,
    output logic [15:0] o_chan3_value,
    output logic [1:0] o_pair_odd_active
);
    import tcc_pkg::*;

    logic [15:0] count_q;
    logic overflow_q;
    logic overflow;
    logic [15:0] value_q [TCC_CHANNELS];
    logic [1:0] odd_active_q;
    logic [1:0] odd_last_q;
    logic [1:0] link;
    logic [3:0] rise;
    logic [3:0] fall;
    logic [3:0] flag_q;
    logic [3:0] flag_d;
    logic [3:0] irq_q;
    logic [3:0] pin_q;
    logic [3:0] oe_q;
    logic [3:0] match;
    logic [3:0] capture;
    logic [15:0] period_q;

    assign link = {i_pair23_link_bit, i_pair01_link_bit};
    assign overflow = i_enable && (count_q == i_modulo);
    assign o_counter = count_q;
    assign o_overflow_flag = overflow_q;
    assign o_chan_flag = flag_q;
    assign o_chan_irq = irq_q;
    assign o_chan_pin = pin_q;
    assign o_chan_pin_oe = oe_q;
    assign o_chan0_value = value_q[0];
    assign o_chan1_value = value_q[1];
    assign o_chan2_value = value_q[2];
    assign o_chan3_value = value_q[3];
    assign o_pair_odd_active = odd_active_q;

    // shared up-counter, wraps to zero after the modulo value
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
            count_q <= TCC_COUNT_RESET;
        else if (overflow)
            count_q <= TCC_COUNT_RESET;
        else if (i_enable)
            count_q <= count_q + 16'h0001;
    end

    // sticky overflow flag; a rollover beats a clear in the same cycle
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
            overflow_q <= 1'b0;
        else if (overflow)
            overflow_q <= 1'b1;
        else if (i_enable && i_overflow_clear)
            overflow_q <= 1'b0;
    end

    // per pair: which register governs, swapped at overflow while linked, forced back to even at once when unlinked
    for (genvar p = 0; p < 2; p++)
    begin : g_pair
        always_ff @(posedge i_clock or negedge i_resetn)
        begin
            if (!i_resetn)
            begin
                odd_active_q[p] <= 1'b0;
                odd_last_q[p] <= 1'b0;
            end
            else if (i_enable)
            begin
                if (!link[p])
                begin
                    odd_active_q[p] <= 1'b0; // even registers lead after linking
                    odd_last_q[p] <= 1'b0;
                end
                else
                begin
                    if (i_value_write[2*p+1])
                        odd_last_q[p] <= 1'b1;
                    else if (i_value_write[2*p])
                        odd_last_q[p] <= 1'b0;
                    if (overflow)
                        odd_active_q[p] <= i_value_write[2*p+1] ? 1'b1 :
                            i_value_write[2*p] ? 1'b0 : odd_last_q[p];
                end
            end
        end
    end

    a_link_handover: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (i_enable && link[0] && odd_last_q[0] && !odd_active_q[0] && overflow && !(|i_value_write[1:0]))
        |=> odd_active_q[0])
        else $error("written odd register did not take over at overflow");

    a_link_hold: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (link[1] && !overflow && i_enable) |=> $stable(odd_active_q[1]))
        else $error("pair register swapped outside overflow");

    a_counter_wrap: assert property (@(posedge i_clock) disable iff (!i_resetn)
        overflow |=> (count_q == TCC_COUNT_RESET) && overflow_q)
        else $error("counter did not wrap with overflow flag");

    // own count of enabled cycles since the last rollover, so the period check does not lean on count_q
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
            period_q <= TCC_COUNT_RESET;
        else if (i_enable)
            period_q <= overflow ? TCC_COUNT_RESET : period_q + 16'h0001;
    end
    a_pwm8_period: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (overflow && i_modulo == TCC_PWM8_MODULO) |-> (period_q == TCC_PWM8_MODULO))
        else $error("modulo 255 did not give a 256-clock period");

    for (genvar g = 0; g < TCC_CHANNELS; g++)
    begin : g_chan
        localparam int P = g / 2;
        localparam bit EVEN = (g % 2) == 0;
        tcc_mode_e mode;
        logic [1:0] sel;
        logic [15:0] cmp_value;
        logic linked_even;

        tcc_pin_sync u_sync
        (
            .i_clock(i_clock),
            .i_resetn(i_resetn),
            .i_enable(i_enable),
            .i_pin(i_chan_pin[g]),
            .o_rise(rise[g]),
            .o_fall(fall[g])
        );

        assign linked_even = EVEN && link[P];
        assign sel = {i_sel_high[g], i_sel_low[g]};

        // link outranks the lower mode bit; a linked odd channel is left alone
        always_comb
        begin
            if (!EVEN && link[P])
                mode = TCC_RELEASED;
            else if (linked_even || i_mode_low_bit[g])
                mode = TCC_COMPARE;
            else
                mode = TCC_CAPTURE;
        end

        // linked even channel compares the pair's governing register
        assign cmp_value = (linked_even && odd_active_q[P]) ? value_q[g | 1] : value_q[g];
        assign match[g] = i_enable && (mode == TCC_COMPARE) && (count_q == cmp_value);
        assign capture[g] = i_enable && (mode == TCC_CAPTURE) &&
            ((rise[g] && sel[0]) || (fall[g] && sel[1]));
        assign flag_d[g] = (capture[g] || match[g]) ? 1'b1 :
            (i_enable && (i_flag_clear[g] || mode == TCC_RELEASED)) ? 1'b0 : flag_q[g];

        // value register: capture wins over a software write in capture mode
        always_ff @(posedge i_clock or negedge i_resetn)
        begin
            if (!i_resetn)
                value_q[g] <= TCC_VALUE_RESET;
            else if (capture[g])
                value_q[g] <= count_q;
            else if (i_enable && i_value_write[g])
                value_q[g] <= i_value_data;
        end

        // channel event flag and its interrupt request
        always_ff @(posedge i_clock or negedge i_resetn)
        begin
            if (!i_resetn)
            begin
                flag_q[g] <= 1'b0;
                irq_q[g] <= 1'b0;
            end
            else if (i_enable)
            begin
                flag_q[g] <= flag_d[g];
                irq_q[g] <= flag_d[g] && i_irq_enable[g];
            end
        end

        // pin drive: compare action beats an overflow toggle in the same cycle
        always_ff @(posedge i_clock or negedge i_resetn)
        begin
            if (!i_resetn)
            begin
                pin_q[g] <= 1'b0;
                oe_q[g] <= 1'b0;
            end
            else if (i_enable)
            begin
                oe_q[g] <= (mode == TCC_COMPARE) && (sel != TCC_SEL_NONE);
                if (mode == TCC_COMPARE)
                begin
                    if (i_max_duty_bit[g] && !i_toggle_on_overflow[g])
                        pin_q[g] <= 1'b1;
                    else if (match[g])
                    begin
                        case (sel)
                            TCC_SEL_RISE_TOGGLE: pin_q[g] <= !pin_q[g];
                            TCC_SEL_FALL_CLEAR: pin_q[g] <= 1'b0;
                            TCC_SEL_BOTH_SET: pin_q[g] <= 1'b1;
                            default: pin_q[g] <= pin_q[g];
                        endcase
                    end
                    else if (overflow && i_toggle_on_overflow[g])
                        pin_q[g] <= !pin_q[g];
                end
            end
        end

        a_capture_value: assert property (@(posedge i_clock) disable iff (!i_resetn)
            capture[g] |=> (value_q[g] == $past(count_q)) && flag_q[g])
            else $error("capture did not load counter and flag");

        a_match_action: assert property (@(posedge i_clock) disable iff (!i_resetn)
            (match[g] && sel == TCC_SEL_BOTH_SET && !i_max_duty_bit[g]) |=> pin_q[g] && flag_q[g])
            else $error("set-on-match did not drive pin high");

        a_irq_follow: assert property (@(posedge i_clock) disable iff (!i_resetn)
            (i_enable && flag_d[g] && i_irq_enable[g]) |=> irq_q[g])
            else $error("enabled flag gave no interrupt request");

        a_released_pin: assert property (@(posedge i_clock) disable iff (!i_resetn)
            (mode == TCC_RELEASED && i_enable) |=> !oe_q[g] && !flag_q[g] || $past(!i_enable))
            else $error("released odd pin is still driven");

        a_zero_duty: assert property (@(posedge i_clock) disable iff (!i_resetn)
            (mode == TCC_COMPARE && !i_toggle_on_overflow[g] && !i_max_duty_bit[g]
             && sel == TCC_SEL_FALL_CLEAR && !pin_q[g]) |=> !pin_q[g])
            else $error("pin rose with overflow toggle off");

        a_max_duty: assert property (@(posedge i_clock) disable iff (!i_resetn)
            (i_enable && mode == TCC_COMPARE && i_max_duty_bit[g] && !i_toggle_on_overflow[g]) |=> pin_q[g])
            else $error("max duty did not hold pin high");

        a_overflow_toggle: assert property (@(posedge i_clock) disable iff (!i_resetn)
            (overflow && mode == TCC_COMPARE && i_toggle_on_overflow[g] && !match[g] && !i_max_duty_bit[g])
            |=> pin_q[g] != $past(pin_q[g]))
            else $error("pin did not invert at overflow");
    end
endmodule
`default_nettype wire

//--- tcc_pkg.sv
package tcc_pkg;
    localparam int unsigned TCC_COUNT_W = 16;
    localparam int unsigned TCC_CHANNELS = 4;
    localparam int unsigned TCC_SYNC_STAGES = 3;
    // counter, modulo and value register reset values
    localparam logic [15:0] TCC_COUNT_RESET = 16'h0000;
    localparam logic [15:0] TCC_MODULO_RESET = 16'hFFFF;
    localparam logic [15:0] TCC_VALUE_RESET = 16'h0000;
    // 8-bit pwm figures: modulo 255 gives a 256-count period, 128 gives half
    localparam logic [15:0] TCC_PWM8_MODULO = 16'h00FF;
    localparam logic [15:0] TCC_PWM8_HALF = 16'h0080;
    // edge/level select codes, bit 1 is the upper select bit
    localparam logic [1:0] TCC_SEL_NONE = 2'h0;
    localparam logic [1:0] TCC_SEL_RISE_TOGGLE = 2'h1;
    localparam logic [1:0] TCC_SEL_FALL_CLEAR = 2'h2;
    localparam logic [1:0] TCC_SEL_BOTH_SET = 2'h3;
    // what one channel is doing at present
    typedef enum logic [1:0] {TCC_CAPTURE, TCC_COMPARE, TCC_RELEASED} tcc_mode_e;
endpackage

//--- tcc_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module tcc_pin_sync
(
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_enable,
    input wire logic i_pin,
    output logic o_rise,
    output logic o_fall
);
    import tcc_pkg::*;

    logic [TCC_SYNC_STAGES-1:0] sync_q;
    logic level_q;
    logic agree;

    // a change counts only once stages two and three agree
    assign agree = (sync_q[1] == sync_q[2]);
    assign o_rise = agree && sync_q[2] && !level_q;
    assign o_fall = agree && !sync_q[2] && level_q;

    // three-stage chain; stage one feeds stage two only
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
            sync_q <= '0;
        else if (i_enable)
            sync_q <= {sync_q[1:0], i_pin};
    end

    // accepted level, used as the edge reference
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
            level_q <= 1'b0;
        else if (i_enable && agree)
            level_q <= sync_q[2];
    end
endmodule
`default_nettype wire

//--- tcc_pin_partner.sv
`timescale 1ns/1ns
`default_nettype none
// outside world at the channel pins: a pin the block drives reads back its own level,
// a released pin follows whatever the outside circuit puts on it
module tcc_pin_partner
(
    input wire logic [3:0] i_drive,
    input wire logic [3:0] i_oe,
    input wire logic [3:0] i_level,
    output logic [3:0] o_pin
);
    // resolve each wire from the block's enable alone
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            o_pin[i] = i_oe[i] ? i_drive[i] : i_level[i];
    end
endmodule
`default_nettype wire

//--- timer_capture_compare_pwm_bench.sv
`timescale 1ns/1ns
`default_nettype none
module timer_capture_compare_pwm_bench;
    import tcc_pkg::*;
    logic i_clock = 1'b0, i_resetn = 1'b0, en = 1'b1, ovc = 1'b0, l01 = 1'b0, l23 = 1'b0, ovf;
    logic [15:0] modulo = TCC_PWM8_MODULO, wdata = 16'h0000, cnt, v0, v1, v2, v3;
    logic [3:0] mode = 4'h1, sh = 4'h1, sl = 4'h0, tov = 4'h1, maxd = 4'h0, ie = 4'h5, fclr = 4'h0, wr = 4'h0;
    logic [3:0] lvl = 4'h0, pin_in, flag, irq, pin, oe;
    logic [1:0] odd;
    integer error_cnt = 0, comparisons = 0, seed = 32'h97EA3CA2, e, s, m, lk, c, ov;
    integer m_cnt, m_ovf, m_pin[4], m_flag[4], m_val[4], m_last[2], m_act[2], m_cmp[2], m_lk[2], m_oe[2];

    always #50 i_clock = ~i_clock;

    tcc_timer_channels uut (.i_clock(i_clock), .i_resetn(i_resetn), .i_enable(en), .i_modulo(modulo),
        .i_overflow_clear(ovc), .i_pair01_link_bit(l01), .i_pair23_link_bit(l23), .i_mode_low_bit(mode),
        .i_sel_high(sh), .i_sel_low(sl), .i_toggle_on_overflow(tov), .i_max_duty_bit(maxd), .i_irq_enable(ie),
        .i_flag_clear(fclr), .i_value_write(wr), .i_value_data(wdata), .i_chan_pin(pin_in), .o_counter(cnt),
        .o_overflow_flag(ovf), .o_chan_flag(flag), .o_chan_irq(irq), .o_chan_pin(pin), .o_chan_pin_oe(oe),
        .o_chan0_value(v0), .o_chan1_value(v1), .o_chan2_value(v2), .o_chan3_value(v3), .o_pair_odd_active(odd));
    tcc_pin_partner partner (.i_drive(pin), .i_oe(oe), .i_level(lvl), .o_pin(pin_in));

    // cycle model of counter and even compare channels; compares use values from before the edge
    always @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            m_cnt = 0;
            m_ovf = 0;
            m_pin = '{0, 0, 0, 0};
            m_flag = '{0, 0, 0, 0};
            m_val = '{0, 0, 0, 0};
            m_last = '{0, 0};
            m_act = '{0, 0};
            m_cmp = '{0, 0};
            m_lk = '{0, 0};
            m_oe = '{0, 0};
        end
        else if (en)
        begin
            ov = (m_cnt == modulo);
            for (int k = 0; k < 2; k++)
            begin
                e = 2 * k;
                s = {sh[e], sl[e]};
                lk = k ? l23 : l01;
                m = m_act[k] ? m_val[e + 1] : m_val[e];
                m_lk[k] = lk;
                m_cmp[k] = lk | mode[e];
                m_oe[k] = m_cmp[k] && s != 0;
                if (m_cmp[k] && maxd[e] && !tov[e])
                    m_pin[e] = 1;
                else if (m_cmp[k] && m_cnt == m && s != 0)
                    m_pin[e] = (s == 1) ? !m_pin[e] : (s == 3);
                else if (m_cmp[k] && ov && tov[e])
                    m_pin[e] = !m_pin[e];
                m_flag[e] = (m_cmp[k] && m_cnt == m) ? 1 : (fclr[e] || !m_cmp[k]) ? 0 : m_flag[e];
                m_last[k] = !lk ? 0 : wr[e + 1] ? 1 : wr[e] ? 0 : m_last[k];
                m_act[k] = !lk ? 0 : ov ? m_last[k] : m_act[k];
            end
            for (int i = 0; i < 4; i++)
                m_val[i] = wr[i] ? wdata : m_val[i];
            m_ovf = ov ? 1 : ovc ? 0 : m_ovf;
            m_cnt = ov ? 0 : m_cnt + 1;
        end
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // counter, overflow flag, values and even compare-channel outputs against the model, half a cycle after the edge settled it
    always @(negedge i_clock)
    begin
        if (i_resetn)
        begin
            check("counter", 16'(m_cnt), cnt);
            check("overflow flag", 16'(m_ovf), {15'h0000, ovf});
            for (int k = 0; k < 2; k++)
            begin
                if (m_cmp[k])
                begin
                    check("pin", 16'(m_pin[2 * k]), {15'h0000, pin[2 * k]});
                    check("pin oe", 16'(m_oe[k]), {15'h0000, oe[2 * k]});
                    check("even value", 16'(m_val[2 * k]), k ? v2 : v0);
                    check("flag", 16'(m_flag[2 * k]), {15'h0000, flag[2 * k]});
                    check("irq", 16'(m_flag[2 * k] & ie[2 * k]), {15'h0000, irq[2 * k]});
                end
                check("odd value", 16'(m_val[2 * k + 1]), k ? v3 : v1);
                if (m_lk[k])
                begin
                    check("odd active", 16'(m_act[k]), {15'h0000, odd[k]});
                    check("odd oe", 16'h0000, {15'h0000, oe[2 * k + 1]});
                end
            end
        end
    end

    task tick(input integer n);
        repeat (n) @(negedge i_clock);
    endtask

    // wait for the counter to show zero again; c holds the cycles waited
    task to_wrap;
        c = 1;
        tick(1);
        while (cnt !== 16'h0000 && c < 300)
        begin
            tick(1);
            c++;
        end
    endtask

    task write(input integer ch, input logic [15:0] d);
        wdata = d;
        wr[ch] = 1'b1;
        tick(1);
        wr[ch] = 1'b0;
    endtask

    // move channel 2's pin; the sync chain means the capture lands exactly three counts late
    task edge2(input logic lv, input logic hit);
        logic [15:0] c0, old, lag;
        c0 = cnt;
        old = v2;
        lvl[2] = lv;
        tick(6);
        lag = (v2 - c0) & 16'h00FF;
        if (hit)
        begin
            check("capture lag", 16'h0003, lag);
            check("capture flag", 16'h0001, {15'h0000, flag[2]});
            check("capture irq", 16'h0001, {15'h0000, irq[2]});
        end
        else
            check("no capture", old, v2);
        fclr[2] = 1'b1;
        tick(1);
        fclr[2] = 1'b0;
        check("capture flag clear", 16'h0000, {15'h0000, flag[2]});
    endtask

    task results;
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        tick(6);
        i_resetn = 1'b1;
        // clear-on-match pwm at half value, one full period timed
        write(0, TCC_PWM8_HALF);
        to_wrap();
        to_wrap();
        check("period", 16'h0100, 16'(c));
        // every compare action; invert only with the overflow toggle off
        for (int a = 1; a < 4; a++)
        begin
            {sh[0], sl[0]} = 2'(a);
            tov[0] = (a != 1);
            write(0, 16'($random(seed)) & 16'h00FF);
            to_wrap();
            to_wrap();
        end
        // smaller value after the match already passed: no match this period
        {sh[0], sl[0]} = 2'h2;
        tick(100);
        write(0, 16'h0020);
        to_wrap();
        to_wrap();
        tov[0] = 1'b0;
        to_wrap();
        maxd[0] = 1'b1;
        to_wrap();
        maxd[0] = 1'b0;
        tov[0] = 1'b1;
        // buffered pair 0/1: only the inactive register is written
        l01 = 1'b1;
        tick(20);
        write(1, 16'($random(seed)) & 16'h00FF | 16'h0010);
        to_wrap();
        to_wrap();
        write(0, 16'h0030);
        to_wrap();
        to_wrap();
        l01 = 1'b0;
        ovc = 1'b1;
        tick(1);
        ovc = 1'b0;
        // capture on channel 2 for every edge selection, both pin edges each
        for (int a = 1; a < 4; a++)
        begin
            {sh[2], sl[2]} = 2'(a);
            tick(2);
            edge2(1'b1, a[0]);
            edge2(1'b0, a[1]);
        end
        // link 2/3 with the mode bit still clear: the link wins; a known even value first, as the model has no capture
        write(2, 16'h0040);
        fclr[2] = 1'b1;
        l23 = 1'b1;
        tick(1);
        fclr[2] = 1'b0;
        write(3, 16'($random(seed)) & 16'h00FF);
        to_wrap();
        to_wrap();
        en = 1'b0;
        tick(10);
        en = 1'b1;
        to_wrap();
        results();
    end

    // hang guard, far beyond the few thousand cycles the sequence needs
    initial
    begin
        #(100 * 30000);
        error_cnt++;
        results();
    end
endmodule
`default_nettype wire
